// >>> pkg/tpp_pkg.sv
package tpp_pkg;
  localparam logic [31:0] REG_CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] REG_ABS_LO_ADDR = 32'h0000_0004;
  localparam logic [31:0] REG_ABS_HI_ADDR = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS_ADDR = 32'h0000_000c;
  localparam logic [31:0] REG_COUNT_ADDR  = 32'h0000_0010;
  localparam int CTRL_FORMAT_BIT  = 0;
  localparam int CTRL_TAG_EN_BIT  = 1;
  localparam int CTRL_ABS_BIT     = 6;
  localparam int CTRL_TFMT_LO     = 2;
  localparam int CTRL_TFMT_HI     = 3;
  localparam int CTRL_TYPE_LO     = 8;
  localparam int CTRL_TYPE_HI     = 11;
  localparam int CTRL_CONTENT_LO  = 12;
  localparam int CTRL_CONTENT_HI  = 13;
  localparam int CW_TAG_BIT       = 31;
  localparam int CW_TYPE_LO       = 27;
  localparam int CW_CONTENT_LO    = 29;
  localparam int REL_TIME_W       = 48;
  localparam logic [3:0] TYPE_MAX = 4'h3;
  localparam logic [1:0] CONTENT_MAX = 2'h1;
  localparam logic [15:0] ZERO16  = 16'h0000;

  typedef enum logic [3:0] {
    TPP_IDLE, TPP_CW_LO, TPP_CW_HI, TPP_TAG, TPP_LEN_LO, TPP_LEN_HI, TPP_DATA, TPP_FILL
  } tpp_state_t;

  typedef struct packed {
    logic        valid;
    logic        first;
    logic        last;
    logic [15:0] word;
  } tpp_out_t;
endpackage : tpp_pkg

// >>> hw/tpp_packetizer.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module tpp_packetizer
  import tpp_pkg::*;
#(
  parameter int LEN_W = 16
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              msg_start,
  input  wire logic [LEN_W-1:0]  msg_len,
  input  wire logic              msg_last,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  input  wire logic              pos_first,
  output logic                   byte_ready,
  output logic                   msg_ready,
  output tpp_out_t               pkt_out,
  input  wire logic              pkt_ready
);
  logic [31:0]           ctrl_ff, nxt_ctrl;
  logic [31:0]           abs_lo_ff, nxt_abs_lo;
  logic [31:0]           abs_hi_ff, nxt_abs_hi;
  logic [31:0]           hrdata_ff, nxt_hrdata;
  logic                  wr_pend_ff, nxt_wr_pend;
  logic [31:0]           wr_addr_ff, nxt_wr_addr;
  logic [31:0]           pkt_cnt_ff, nxt_pkt_cnt;
  logic [REL_TIME_W-1:0] rel_ff, nxt_rel;
  logic [63:0]           tag_ff, nxt_tag;
  logic [1:0]            tag_ix_ff, nxt_tag_ix;
  tpp_state_t            st_ff, nxt_st;
  logic [LEN_W-1:0]      len_ff, nxt_len;
  logic [LEN_W-1:0]      rem_ff, nxt_rem;
  logic                  last_ff, nxt_last;
  logic                  half_ff, nxt_half;
  logic [7:0]            lo_byte_ff, nxt_lo_byte;
  logic                  fmt1_ff, nxt_fmt1;
  logic                  tag_en_ff, nxt_tag_en;
  logic                  tagged_ff, nxt_tagged;
  logic [31:0]           cw_ff, nxt_cw;
  tpp_out_t              out_ff, nxt_out;
  logic                  bready_ff, nxt_bready;
  logic                  mready_ff, nxt_mready;
  logic                  addr_ok;
  logic                  can_emit;

  function automatic logic [63:0] time_tag(input logic                  abs_sel,
                                           input logic [REL_TIME_W-1:0] rel,
                                           input logic [31:0]           alo,
                                           input logic [31:0]           ahi);
    logic [63:0] t;
    t = {{(64-REL_TIME_W){1'b0}}, rel};
    if (abs_sel)
    begin
      t = {ahi, alo};
    end
    return t;
  endfunction : time_tag

  assign addr_ok  = hsel & htrans[1] & hready;
  assign can_emit = ~out_ff.valid | pkt_ready;

  // Bus slave: zero wait states, writes land in the cycle after the address phase
  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_abs_lo  = abs_lo_ff;
    nxt_abs_hi  = abs_hi_ff;
    nxt_wr_pend = addr_ok & hwrite;
    nxt_wr_addr = addr_ok ? haddr : wr_addr_ff;
    nxt_hrdata  = hrdata_ff;
    if (wr_pend_ff)
    begin
      unique case (wr_addr_ff)
        REG_CTRL_ADDR:   nxt_ctrl   = hwdata;
        REG_ABS_LO_ADDR: nxt_abs_lo = hwdata;
        REG_ABS_HI_ADDR: nxt_abs_hi = hwdata;
        default:         nxt_ctrl   = ctrl_ff;
      endcase
    end
    if (addr_ok & ~hwrite)
    begin
      unique case (haddr)
        REG_CTRL_ADDR:   nxt_hrdata = ctrl_ff;
        REG_ABS_LO_ADDR: nxt_hrdata = abs_lo_ff;
        REG_ABS_HI_ADDR: nxt_hrdata = abs_hi_ff;
        REG_STATUS_ADDR: nxt_hrdata = {27'h0, st_ff, (st_ff != TPP_IDLE)};
        REG_COUNT_ADDR:  nxt_hrdata = pkt_cnt_ff;
        default:         nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff    <= 32'h0000_0000;
      abs_lo_ff  <= 32'h0000_0000;
      abs_hi_ff  <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      hrdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      abs_lo_ff  <= nxt_abs_lo;
      abs_hi_ff  <= nxt_abs_hi;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff  <= nxt_hrdata;
    end
  end

  // Free-running relative counter, wraps at 48 bits
  assign nxt_rel = rel_ff + 48'h0000_0000_0001;

  // Framer
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_len     = len_ff;
    nxt_rem     = rem_ff;
    nxt_last    = last_ff;
    nxt_half    = half_ff;
    nxt_lo_byte = lo_byte_ff;
    nxt_fmt1    = fmt1_ff;
    nxt_tag_en  = tag_en_ff;
    nxt_tagged  = tagged_ff;
    nxt_cw      = cw_ff;
    nxt_tag     = tag_ff;
    nxt_tag_ix  = tag_ix_ff;
    nxt_pkt_cnt = pkt_cnt_ff;
    nxt_out     = out_ff;
    nxt_mready  = 1'b0;
    nxt_bready  = 1'b0;
    if (pkt_ready)
    begin
      nxt_out.valid = 1'b0;
    end
    // Source flags the start of position data on the first byte it offers, ahead of the
    // static data it already holds, so the tag can lead them with no buffer
    if (st_ff == TPP_TAG && fmt1_ff && !tagged_ff && pos_first && byte_valid)
    begin
      nxt_tag    = time_tag(ctrl_ff[CTRL_ABS_BIT], rel_ff, abs_lo_ff, abs_hi_ff);
      nxt_tagged = 1'b1;
    end
    unique case (st_ff)
      TPP_IDLE:
      begin
        nxt_mready = 1'b1;
        if (msg_start && mready_ff)
        begin
          nxt_fmt1   = ctrl_ff[CTRL_FORMAT_BIT];
          nxt_tag_en = ctrl_ff[CTRL_TAG_EN_BIT];
          nxt_len    = msg_len;
          nxt_rem    = msg_len;
          nxt_last   = msg_last;
          nxt_tagged = 1'b0;
          nxt_cw     = 32'h0000_0000;
          nxt_cw[CW_TAG_BIT] = ctrl_ff[CTRL_TAG_EN_BIT];
          if (ctrl_ff[CTRL_FORMAT_BIT])
          begin
            nxt_cw[CW_CONTENT_LO +: 2] = (ctrl_ff[CTRL_CONTENT_HI:CTRL_CONTENT_LO] > CONTENT_MAX)
                                         ? 2'h0 : ctrl_ff[CTRL_CONTENT_HI:CTRL_CONTENT_LO];
          end
          else
          begin
            // Reserved codes collapse to zero so the word stays legal
            nxt_cw[CW_TYPE_LO +: 4] = (ctrl_ff[CTRL_TYPE_HI:CTRL_TYPE_LO] > TYPE_MAX)
                                      ? 4'h0 : ctrl_ff[CTRL_TYPE_HI:CTRL_TYPE_LO];
            nxt_tag = time_tag(ctrl_ff[CTRL_ABS_BIT], rel_ff, abs_lo_ff, abs_hi_ff);
          end
          nxt_mready = 1'b0;
          nxt_st     = TPP_CW_LO;
        end
      end
      TPP_CW_LO:
      if (can_emit)
      begin
        nxt_out = '{valid: 1'b1, first: 1'b1, last: 1'b0, word: cw_ff[15:0]};
        nxt_st  = TPP_CW_HI;
      end
      TPP_CW_HI:
      if (can_emit)
      begin
        nxt_out    = '{valid: 1'b1, first: 1'b0, last: 1'b0, word: cw_ff[31:16]};
        nxt_tag_ix = 2'h0;
        nxt_st     = tag_en_ff ? TPP_TAG : TPP_LEN_LO;
        nxt_half   = 1'b0;
      end
      TPP_TAG:
      // Format 1 waits here with bytes unread until the tag is caught
      if (can_emit && (tagged_ff || !fmt1_ff))
      begin
        // Four halves, low long word first
        nxt_out    = '{valid: 1'b1, first: 1'b0, last: 1'b0, word: tag_ff[tag_ix_ff*16 +: 16]};
        nxt_tag_ix = tag_ix_ff + 2'h1;
        if (tag_ix_ff == 2'h3)
        begin
          nxt_st = TPP_LEN_LO;
        end
      end
      TPP_LEN_LO:
      if (can_emit)
      begin
        nxt_out = '{valid: 1'b1, first: 1'b0, last: 1'b0, word: 16'(len_ff)};
        nxt_st  = TPP_LEN_HI;
      end
      TPP_LEN_HI:
      if (can_emit)
      begin
        nxt_out    = '{valid: 1'b1, first: 1'b0, last: 1'b0, word: ZERO16};
        nxt_half   = 1'b0;
        nxt_bready = (rem_ff != '0);
        nxt_st     = (rem_ff != '0) ? TPP_DATA : TPP_FILL;
      end
      TPP_DATA:
      begin
        // Ready only follows a free output slot, so a high byte never meets a stalled word
        nxt_bready = can_emit && (rem_ff > LEN_W'(1)) || (can_emit && !bready_ff);
        if (byte_valid && bready_ff)
        begin
          nxt_rem = rem_ff - LEN_W'(1);
          if (!half_ff)
          begin
            nxt_lo_byte = byte_data;
            nxt_half    = 1'b1;
            if (rem_ff == LEN_W'(1))
            begin
              nxt_bready = 1'b0;
              nxt_st     = TPP_FILL;
            end
          end
          else
          begin
            nxt_out  = '{valid: 1'b1, first: 1'b0, last: last_ff && rem_ff == LEN_W'(1),
                         word: {byte_data, lo_byte_ff}};
            nxt_half = 1'b0;
            if (rem_ff == LEN_W'(1))
            begin
              nxt_bready = 1'b0;
              nxt_st     = TPP_IDLE;
            end
          end
        end
      end
      TPP_FILL:
      if (can_emit)
      begin
        if (half_ff)
        begin
          nxt_out = '{valid: 1'b1, first: 1'b0, last: last_ff,
                      word: {ZERO16[7:0], lo_byte_ff}};
        end
        nxt_half = 1'b0;
        nxt_st   = TPP_IDLE;
      end
      default: nxt_st = TPP_IDLE;
    endcase
    if (nxt_out.valid && nxt_out.last && !out_ff.last)
    begin
      nxt_pkt_cnt = pkt_cnt_ff + 32'h0000_0001;
    end
  end

  // Data is streamed as it arrives, no store-and-forward, so timing stays live
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rel_ff     <= '0;
      st_ff      <= TPP_IDLE;
      len_ff     <= '0;
      rem_ff     <= '0;
      last_ff    <= 1'b0;
      half_ff    <= 1'b0;
      lo_byte_ff <= 8'h00;
      fmt1_ff    <= 1'b0;
      tag_en_ff  <= 1'b0;
      tagged_ff  <= 1'b0;
      cw_ff      <= 32'h0000_0000;
      tag_ff     <= 64'h0;
      tag_ix_ff  <= 2'h0;
      pkt_cnt_ff <= 32'h0000_0000;
      out_ff     <= '0;
      bready_ff  <= 1'b0;
      mready_ff  <= 1'b0;
    end
    else
    begin
      rel_ff     <= nxt_rel;
      st_ff      <= nxt_st;
      len_ff     <= nxt_len;
      rem_ff     <= nxt_rem;
      last_ff    <= nxt_last;
      half_ff    <= nxt_half;
      lo_byte_ff <= nxt_lo_byte;
      fmt1_ff    <= nxt_fmt1;
      tag_en_ff  <= nxt_tag_en;
      tagged_ff  <= nxt_tagged;
      cw_ff      <= nxt_cw;
      tag_ff     <= nxt_tag;
      tag_ix_ff  <= nxt_tag_ix;
      pkt_cnt_ff <= nxt_pkt_cnt;
      out_ff     <= nxt_out;
      bready_ff  <= nxt_bready;
      mready_ff  <= nxt_mready;
    end
  end

  // Source is trusted to send standard messages only; no filtering here
  assign hrdata     = hrdata_ff;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign pkt_out    = out_ff;
  assign byte_ready = bready_ff;
  assign msg_ready  = mready_ff;
endmodule : tpp_packetizer
`default_nettype wire

// >>> dv/tpp_packetizer_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tpp_packetizer_asserts
  import tpp_pkg::*;
#(
  parameter int LEN_W = 16
)(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             msg_start,
  input wire logic [LEN_W-1:0] msg_len,
  input wire logic             msg_ready,
  input wire tpp_out_t         pkt_out,
  input wire logic             pkt_ready
);
  logic             wr_ff;
  logic             acc;
  logic [31:0]      ctrl_ff;
  logic [15:0]      idx_ff;
  logic [15:0]      tw;
  logic [3:0]       code;
  logic [LEN_W-1:0] len_ff;
  assign acc = pkt_out.valid && pkt_ready;
  assign tw = ctrl_ff[1] ? 16'h0004 : 16'h0000;
  assign code = ctrl_ff[0] ? {(ctrl_ff[13:12] > CONTENT_MAX ? 2'h0 : ctrl_ff[13:12]), 2'h0}
                           : (ctrl_ff[11:8] > TYPE_MAX ? 4'h0 : ctrl_ff[11:8]);
  // Control is only rewritten between packets, so a shadow copy is exact
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ff <= 1'b0;
      ctrl_ff <= 32'h0;
      idx_ff <= 16'h0;
      len_ff <= '0;
    end
    else
    begin
      wr_ff <= hsel && htrans[1] && hready && hwrite && haddr == REG_CTRL_ADDR;
      if (wr_ff) ctrl_ff <= hwdata;
      if (msg_start && msg_ready) len_ff <= msg_len;
      if (acc) idx_ff <= pkt_out.last ? 16'h0 : idx_ff + 16'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_tag_flag; acc && idx_ff == 16'h1 |-> pkt_out.word[15] == ctrl_ff[1]; endproperty
  a_tag_flag: assert property (p_tag_flag) else $error("tag flag wrong");
  property p_code; acc && idx_ff == 16'h1 |-> pkt_out.word[14:11] == code; endproperty
  a_code: assert property (p_code) else $error("code field wrong");
  property p_resv;
    acc && idx_ff < 16'h2 |-> (pkt_out.word & (idx_ff == 16'h0 ? 16'hffff : 16'h07ff)) == 16'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_rel_top; acc && idx_ff == 16'h5 && ctrl_ff[1] && !ctrl_ff[6] |-> pkt_out.word == 16'h0;
  endproperty
  a_rel_top: assert property (p_rel_top) else $error("tag top not zero");
  property p_len; acc && idx_ff == 16'h2 + tw |-> pkt_out.word == 16'(len_ff); endproperty
  a_len: assert property (p_len) else $error("length wrong");
  property p_len_hi; acc && idx_ff == 16'h3 + tw |-> pkt_out.word == 16'h0; endproperty
  a_len_hi: assert property (p_len_hi) else $error("header upper half set");
  property p_fill; acc && pkt_out.last && len_ff[0] |-> pkt_out.word[15:8] == 8'h0; endproperty
  a_fill: assert property (p_fill) else $error("filler not zero");
  property p_last;
    acc && pkt_out.last |-> idx_ff == 16'h3 + tw + 16'((len_ff + LEN_W'(1)) >> 1);
  endproperty
  a_last: assert property (p_last) else $error("packet ends at wrong word");
  property p_first; acc |-> pkt_out.first == (idx_ff == 16'h0); endproperty
  a_first: assert property (p_first) else $error("first flag misplaced");
  property p_hold; pkt_out.valid && !pkt_ready |=> pkt_out.valid && $stable(pkt_out.word);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped in stall");
endmodule : tpp_packetizer_asserts
`default_nettype wire

// >>> dv/tpp_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module tpp_src_model (
  input  wire logic  hclk,
  input  wire logic  msg_ready,
  input  wire logic  byte_ready,
  output logic       msg_start,
  output logic [15:0] msg_len,
  output logic       msg_last,
  output logic       byte_valid,
  output logic [7:0] byte_data,
  output logic       pos_first
);
  initial
  begin
    msg_start = 1'b0;
    msg_len = 16'h0;
    msg_last = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h0;
    pos_first = 1'b0;
  end
  // Only clean 8-bit codes are sent, never vendor-specific content
  task send(input logic [15:0] n, input logic [7:0] sd, input int pf);
    int k;
    msg_start <= 1'b1;
    msg_len <= n;
    msg_last <= 1'b1;
    @(posedge hclk);
    while (msg_ready !== 1'b1) @(posedge hclk);
    msg_start <= 1'b0;
    msg_len <= ~n;
    msg_last <= 1'b0;
    for (k = 0; k < n; k++)
    begin
      byte_valid <= 1'b1;
      byte_data <= sd + 8'(k * 37);
      pos_first <= k == pf;
      @(posedge hclk);
      while (byte_ready !== 1'b1) @(posedge hclk);
    end
    // Released data shows garbage so a stale byte cannot pass as valid
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
    pos_first <= 1'b0;
  endtask : send
endmodule : tpp_src_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tpp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, msg_start, msg_last;
  logic        byte_valid, pos_first, byte_ready, msg_ready, pkt_ready;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, alo, ahi, cw, rng;
  logic [15:0] msg_len;
  logic [7:0]  byte_data, sd, b0, b1;
  logic [16:0] exp_q[$];
  logic [15:0] got_q[$];
  tpp_out_t    pkt_out;
  int          n_errors, total_checks, t, i;
  int          fm[7] = '{0, 0, 0, 0, 1, 1, 0};
  int          tg[7] = '{0, 1, 1, 0, 1, 1, 0};
  int          ab[7] = '{0, 0, 1, 0, 1, 0, 0};
  int          cd[7] = '{0, 1, 2, 3, 1, 0, 5};
  int          ln[7] = '{1, 4, 7, 2, 5, 6, 3};
  tpp_packetizer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .msg_start(msg_start),
    .msg_len(msg_len), .msg_last(msg_last), .byte_valid(byte_valid), .byte_data(byte_data),
    .pos_first(pos_first), .byte_ready(byte_ready), .msg_ready(msg_ready),
    .pkt_out(pkt_out), .pkt_ready(pkt_ready));
  tpp_src_model u_src (.hclk(hclk), .msg_ready(msg_ready), .byte_ready(byte_ready),
    .msg_start(msg_start), .msg_len(msg_len), .msg_last(msg_last),
    .byte_valid(byte_valid), .byte_data(byte_data), .pos_first(pos_first));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Random sink stalls exercise the output hold
  always @(posedge hclk)
  begin
    if (pkt_out.valid && pkt_ready) got_q.push_back(pkt_out.word);
    pkt_ready <= (xs() & 32'h3) != 32'h0;
  end
  initial
  begin
    #500000;
    n_errors++;
    conclude();
  end
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    rng = 32'h2763;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Absolute time source starts clear
    ahb(1'b0, REG_ABS_LO_ADDR, 32'h0);
    chk(rd, 32'h0);
    for (t = 0; t < 7; t++)
    begin
      alo = xs();
      ahi = xs();
      sd = 8'(xs());
      ahb(1'b1, REG_ABS_LO_ADDR, alo);
      ahb(1'b1, REG_ABS_HI_ADDR, ahi);
      ahb(1'b0, REG_ABS_HI_ADDR, 32'h0);
      chk(rd, ahi);
      ahb(1'b1, REG_CTRL_ADDR, 32'(fm[t] | tg[t] << 1 | ab[t] << 6 | cd[t] << (fm[t] ? 12 : 8)));
      cw = {tg[t][0], fm[t] ? {2'(cd[t] > 1 ? 0 : cd[t]), 29'h0} : {4'(cd[t] > 3 ? 0 : cd[t]), 27'h0}};
      exp_q.delete();
      got_q.delete();
      exp_q.push_back({1'b0, cw[15:0]});
      exp_q.push_back({1'b0, cw[31:16]});
      // Relative counter words are free running, so only the zero top word is predicted
      if (tg[t] != 0)
      begin
        exp_q.push_back({ab[t] == 0, alo[15:0]});
        exp_q.push_back({ab[t] == 0, alo[31:16]});
        exp_q.push_back({ab[t] == 0, ahi[15:0]});
        exp_q.push_back({1'b0, ab[t] != 0 ? ahi[31:16] : 16'h0});
      end
      exp_q.push_back({1'b0, ln[t][15:0]});
      exp_q.push_back(17'h0);
      for (i = 0; i < ln[t]; i += 2)
      begin
        b0 = sd + 8'(i * 37);
        b1 = (i + 1 < ln[t]) ? sd + 8'((i + 1) * 37) : 8'h0;
        exp_q.push_back({1'b0, b1, b0});
      end
      // Start of position data is flagged on the first byte offered; static data follow it
      u_src.send(16'(ln[t]), sd, 0);
      i = 0;
      while (got_q.size() < exp_q.size() && i < 2000)
      begin
        @(posedge hclk);
        i++;
      end
      chk(got_q.size(), exp_q.size());
      for (i = 0; i < exp_q.size() && i < got_q.size(); i++)
        if (!exp_q[i][16])
          chk({16'h0, got_q[i]}, {16'h0, exp_q[i][15:0]});
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule : testbench
bind tpp_packetizer tpp_packetizer_asserts #(.LEN_W(LEN_W)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .msg_start(msg_start), .msg_len(msg_len),
  .msg_ready(msg_ready), .pkt_out(pkt_out), .pkt_ready(pkt_ready));
`default_nettype wire
